// file: src/stx_exec.sv
// How it works
// RULE1 - swap memory nibbles into work register
// RULE2 - read, rewrite byte; skip when zero
// RULE3 - copy byte to work register; skip if zero
// RULE4 - skip when selected memory bit clear
// RULE5 - taken skip adds one dummy cycle
// RULE6 - table read via high and low pointers
// RULE7 - last-page table read via low pointer
// RULE8 - xor memory into work register, zero flag
// RULE9 - xor result written to memory, zero flag
// RULE10 - xor immediate into work register, zero flag
module stx_exec
	import stx_pkg::*;
#(
	parameter int          PROG_AW   = 16,
	parameter logic [15:0] LAST_PAGE = 16'hFF00,
	parameter bit          HAS_HIGH  = 1'b1
) (
	// clock and reset
	input  wire logic          mclk_i,
	input  wire logic          rst_i,
	// instruction issue from decode
	input  wire logic          issue_valid_i,
	input  wire stx_issue_type issue_i,
	output logic               busy_o,
	// data memory
	input  wire logic [7:0]    mem_rdata_i,
	output logic [7:0]         mem_raddr_o,
	output stx_mem_wr_type     mem_wr_o,
	// table pointers and program memory
	input  wire logic [7:0]    table_pointer_low_i,
	input  wire logic [7:0]    table_pointer_high_i,
	input  wire logic [15:0]   prog_rdata_i,
	output logic [15:0]        prog_addr_o,
	output logic               prog_rd_o,
	// work register, latch and flags
	output logic [7:0]         work_register_o,
	output logic [7:0]         table_high_latch_o,
	output logic               zero_flag_o,
	output logic               zero_we_o,
	output logic               skip_o,
	output logic               dummy_o,
	output logic               done_o
);

	////////////////////////////////////////////////////////////////////////
	// state
	stx_state_type state;
	stx_state_type next_state;
	stx_issue_type cur;
	stx_issue_type next_cur;
	logic [7:0]    work;
	logic [7:0]    next_work;
	logic [7:0]    latch;
	logic [7:0]    next_latch;
	logic          zflag;
	logic          next_zflag;
	logic          zwe;
	logic          next_zwe;
	logic          skip;
	logic          next_skip;
	logic          dummy;
	logic          next_dummy;
	logic          done;
	logic          next_done;
	logic          busy;
	logic          next_busy;
	stx_mem_wr_type mwr;
	stx_mem_wr_type next_mwr;
	logic [7:0]    raddr;
	logic [7:0]    next_raddr;
	logic [15:0]   paddr;
	logic [15:0]   next_paddr;
	logic          prd;
	logic          next_prd;
	logic [7:0]    res;
	logic          take;
	logic          is_table;
	logic          skip_cond;

	// program addresses wrap inside the fitted program memory
	localparam logic [15:0] PADDR_MASK = 16'((32'h1 << PROG_AW) - 32'h1);

	////////////////////////////////////////////////////////////////////////
	// operand decode: acceptance, result and skip test
	always_comb begin
		take      = (state == STX_ST_IDLE) && issue_valid_i &&
			(issue_i.op != STX_OP_NONE);
		is_table  = (issue_i.op == STX_OP_TBL_PAGE) ||
			(issue_i.op == STX_OP_TBL_LAST);
		res       = 8'h00;
		skip_cond = 1'b0;
		// the held instruction sees its byte one cycle after issue
		unique case (cur.op)
			STX_OP_SWAP_REG: begin
				res = {mem_rdata_i[3:0], mem_rdata_i[7:4]}; // RULE1
			end
			STX_OP_SKIP_NULL: begin
				res       = mem_rdata_i; // RULE2
				skip_cond = (mem_rdata_i == 8'h00); // RULE2
			end
			STX_OP_SKIP_MOVE: begin
				res       = mem_rdata_i; // RULE3
				skip_cond = (mem_rdata_i == 8'h00); // RULE3
			end
			STX_OP_SKIP_BIT: begin
				skip_cond = ~mem_rdata_i[cur.bit_sel]; // RULE4
			end
			STX_OP_XOR_REG: begin
				res = work ^ mem_rdata_i; // RULE8
			end
			STX_OP_XOR_MEM: begin
				res = mem_rdata_i ^ work; // RULE9
			end
			STX_OP_XOR_IMM: begin
				res = work ^ cur.imm; // RULE10
			end
			default: begin
				// table reads and unused codes produce nothing here
				res = 8'h00;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencer: state, held instruction and handshake pulses
	always_comb begin
		next_state = state;
		next_cur   = cur;
		next_raddr = raddr;
		next_busy  = busy;
		next_skip  = 1'b0;
		next_dummy = 1'b0;
		next_done  = 1'b0;
		unique case (state)
			STX_ST_IDLE: begin
				// issues are taken only here, so busy refuses the rest
				if (take) begin
					next_cur   = issue_i;
					next_raddr = issue_i.mem_addr;
					next_busy  = 1'b1;
					if (is_table) begin
						next_state = STX_ST_TBL;
					end else begin
						next_state = STX_ST_EXEC;
					end
				end
			end
			STX_ST_EXEC: begin
				next_skip = skip_cond;
				if (skip_cond) begin
					// a taken skip holds the core one more cycle
					next_state = STX_ST_DUMMY; // RULE5
				end else begin
					next_state = STX_ST_IDLE;
					next_busy  = 1'b0;
					next_done  = 1'b1;
				end
			end
			STX_ST_TBL: begin
				next_state = STX_ST_IDLE;
				next_busy  = 1'b0;
				next_done  = 1'b1;
			end
			STX_ST_DUMMY: begin
				next_dummy = 1'b1; // RULE5
				next_state = STX_ST_IDLE;
				next_busy  = 1'b0;
				next_done  = 1'b1;
			end
		endcase
	end

	// sequencer registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= STX_ST_IDLE;
			cur   <= '0;
			raddr <= STX_MEM_ADDR_RST;
			busy  <= 1'b0;
			skip  <= 1'b0;
			dummy <= 1'b0;
			done  <= 1'b0;
		end else begin
			state <= next_state;
			cur   <= next_cur;
			raddr <= next_raddr;
			busy  <= next_busy;
			skip  <= next_skip;
			dummy <= next_dummy;
			done  <= next_done;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program memory read: address and one-cycle strobe
	always_comb begin
		next_paddr = paddr;
		next_prd   = 1'b0;
		if (take && issue_i.op == STX_OP_TBL_PAGE) begin
			// with no high pointer the low pointer addresses alone
			if (HAS_HIGH) begin
				next_paddr = PADDR_MASK & // RULE6
					{table_pointer_high_i, table_pointer_low_i};
			end else begin
				next_paddr = PADDR_MASK & // RULE6
					{8'h00, table_pointer_low_i};
			end
			next_prd = 1'b1;
		end else if (take && issue_i.op == STX_OP_TBL_LAST) begin
			next_paddr = PADDR_MASK & // RULE7
				(LAST_PAGE | {8'h00, table_pointer_low_i});
			next_prd   = 1'b1;
		end
	end

	// program read registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			paddr <= STX_PADDR_RST;
			prd   <= 1'b0;
		end else begin
			paddr <= next_paddr;
			prd   <= next_prd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// results: work register, table latch, zero flag and memory write
	always_comb begin
		next_work  = work;
		next_latch = latch;
		next_zflag = zflag;
		next_zwe   = 1'b0;
		next_mwr   = '0;
		if (state == STX_ST_EXEC) begin
			unique case (cur.op)
				STX_OP_SWAP_REG: begin
					// memory is left as it is
					next_work = res; // RULE1
				end
				STX_OP_SKIP_NULL: begin
					// the byte goes back to memory unchanged
					next_mwr = '{we: 1'b1, addr: cur.mem_addr, // RULE2
						data: res};
				end
				STX_OP_SKIP_MOVE: begin
					next_work = res; // RULE3
				end
				STX_OP_XOR_REG: begin
					next_work  = res; // RULE8
					next_zflag = (res == 8'h00); // RULE8
					next_zwe   = 1'b1;
				end
				STX_OP_XOR_MEM: begin
					next_mwr   = '{we: 1'b1, addr: cur.mem_addr, // RULE9
						data: res};
					next_zflag = (res == 8'h00); // RULE9
					next_zwe   = 1'b1;
				end
				STX_OP_XOR_IMM: begin
					next_work  = res; // RULE10
					next_zflag = (res == 8'h00); // RULE10
					next_zwe   = 1'b1;
				end
				default: begin
					// bit test and table reads change no result here
					next_zwe = 1'b0;
				end
			endcase
		end else if (state == STX_ST_TBL) begin
			// program word is taken in the same cycle as the read strobe
			next_mwr   = '{we: 1'b1, addr: cur.mem_addr, // RULE6
				data: prog_rdata_i[7:0]};
			next_latch = prog_rdata_i[15:8]; // RULE7
		end
	end

	// result registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			work  <= STX_WORK_RST;
			latch <= STX_LATCH_RST;
			zflag <= 1'b0;
			zwe   <= 1'b0;
			mwr   <= '0;
		end else begin
			work  <= next_work;
			latch <= next_latch;
			zflag <= next_zflag;
			zwe   <= next_zwe;
			mwr   <= next_mwr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flip-flops
	assign busy_o             = busy;
	assign mem_raddr_o        = raddr;
	assign mem_wr_o           = mwr;
	assign prog_addr_o        = paddr;
	assign prog_rd_o          = prd;
	assign work_register_o    = work;
	assign table_high_latch_o = latch;
	assign zero_flag_o        = zflag;
	assign zero_we_o          = zwe;
	assign skip_o             = skip;
	assign dummy_o            = dummy;
	assign done_o             = done;

endmodule : stx_exec

// file: src/stx_pkg.sv
package stx_pkg;

	// operation selector handed over by the decode stage
	typedef enum logic [3:0] {
		STX_OP_NONE       = 4'h0,
		STX_OP_SWAP_REG   = 4'h1,
		STX_OP_SKIP_NULL  = 4'h2,
		STX_OP_SKIP_MOVE  = 4'h3,
		STX_OP_SKIP_BIT   = 4'h4,
		STX_OP_TBL_PAGE   = 4'h5,
		STX_OP_TBL_LAST   = 4'h6,
		STX_OP_XOR_REG    = 4'h7,
		STX_OP_XOR_MEM    = 4'h8,
		STX_OP_XOR_IMM    = 4'h9
	} stx_op_type;

	// widths and reset values
	localparam int         STX_DATA_W       = 8;
	localparam int         STX_PROG_W       = 16;
	localparam int         STX_PADDR_W      = 16;
	localparam logic [7:0] STX_WORK_RST     = 8'h00;
	localparam logic [7:0] STX_LATCH_RST    = 8'h00;
	localparam logic [7:0] STX_MEM_ADDR_RST = 8'h00;
	localparam logic [15:0] STX_PADDR_RST   = 16'h0000;

	// one instruction issued by the decode stage
	typedef struct packed {
		stx_op_type op;
		logic [7:0] mem_addr;
		logic [2:0] bit_sel;
		logic [7:0] imm;
	} stx_issue_type;

	// data memory write request
	typedef struct packed {
		logic       we;
		logic [7:0] addr;
		logic [7:0] data;
	} stx_mem_wr_type;

	// execution states, one-hot
	typedef enum logic [3:0] {
		STX_ST_IDLE  = 4'b0001,
		STX_ST_EXEC  = 4'b0010,
		STX_ST_TBL   = 4'b0100,
		STX_ST_DUMMY = 4'b1000
	} stx_state_type;

endpackage : stx_pkg

// file: dv/stx_exec_props.sv
module stx_exec_props
	import stx_pkg::*;
(
	input wire logic           mclk_i,
	input wire logic           rst_i,
	input wire logic           issue_valid_i,
	input wire stx_issue_type  issue_i,
	input wire logic           busy_o,
	input wire stx_mem_wr_type mem_wr_o,
	input wire logic [7:0]     work_register_o,
	input wire logic           prog_rd_o,
	input wire logic           zero_flag_o,
	input wire logic           zero_we_o,
	input wire logic           skip_o,
	input wire logic           dummy_o,
	input wire logic           done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic take;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// an issue is accepted only while idle
	assign take = issue_valid_i && !busy_o && issue_i.op != STX_OP_NONE;
	skip_dummy_a: assert property (skip_o |=> dummy_o && done_o)
		else $error("no dummy after skip");
	dummy_cause_a: assert property (dummy_o |-> $past(skip_o))
		else $error("dummy without skip");
	swap_flags_a: assert property (take && issue_i.op == STX_OP_SWAP_REG
		|-> ##2 done_o && !zero_we_o && !mem_wr_o.we) else $error("swap");
	xor_reg_a: assert property (take && issue_i.op == STX_OP_XOR_REG
		|-> ##2 done_o && zero_we_o && !mem_wr_o.we) else $error("xor reg");
	zero_work_a: assert property (zero_we_o && !mem_wr_o.we
		|-> zero_flag_o == (work_register_o == 8'h00)) else $error("zero");
	zero_mem_a: assert property (zero_we_o && mem_wr_o.we
		|-> zero_flag_o == (mem_wr_o.data == 8'h00)) else $error("zero m");
	null_write_a: assert property (take && issue_i.op == STX_OP_SKIP_NULL
		|-> ##2 mem_wr_o.we && mem_wr_o.addr == $past(issue_i.mem_addr, 2))
		else $error("no rewrite");
	table_write_a: assert property (prog_rd_o |=> mem_wr_o.we && done_o)
		else $error("table write");
endmodule : stx_exec_props

bind stx_exec stx_exec_props u_props (.mclk_i, .rst_i, .issue_valid_i,
	.issue_i, .busy_o, .mem_wr_o, .work_register_o, .prog_rd_o,
	.zero_flag_o, .zero_we_o, .skip_o, .dummy_o, .done_o);

// file: dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import stx_pkg::*;
	logic           mclk_i, rst_i, issue_valid_i, busy_o, prog_rd_o;
	logic           zero_flag_o, zero_we_o, skip_o, dummy_o, done_o, sk;
	stx_issue_type  issue_i;
	stx_mem_wr_type mem_wr_o;
	logic [7:0]     mem_rdata_i, mem_raddr_o, work_register_o, mem [256];
	logic [7:0]     table_pointer_low_i, table_pointer_high_i;
	logic [7:0]     table_high_latch_o;
	logic [15:0]    prog_rdata_i, prog_addr_o;
	int             n_errors, comparisons, n_cyc, base;
	stx_exec dut (.mclk_i, .rst_i, .issue_valid_i, .issue_i, .busy_o,
		.mem_rdata_i, .mem_raddr_o, .mem_wr_o, .table_pointer_low_i,
		.table_pointer_high_i, .prog_rdata_i, .prog_addr_o, .prog_rd_o,
		.work_register_o, .table_high_latch_o, .zero_flag_o, .zero_we_o,
		.skip_o, .dummy_o, .done_o);
	////////////////////////////////////////////////////////////////////////
	// memories answering the block
	always #20 mclk_i = ~mclk_i;
	assign mem_rdata_i = mem[mem_raddr_o];
	assign prog_rdata_i = {prog_addr_o[15:8] ^ 8'hA5, prog_addr_o[7:0] ^ 8'h5A};
	always @(posedge mclk_i) begin
		if (mem_wr_o.we) mem[mem_wr_o.addr] <= mem_wr_o.data;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		comparisons++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("errors=%0d comparisons=%0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : report_and_stop
	// issue one instruction and wait for its completion
	task automatic run(input stx_op_type op, input logic [7:0] a, x);
		@(posedge mclk_i);
		issue_valid_i <= 1'b1;
		issue_i <= '{op, a, 3'h3, x};
		@(posedge mclk_i);
		issue_valid_i <= 1'b0;
		n_cyc = 0;
		sk = 1'b0;
		do begin
			@(negedge mclk_i);
			n_cyc++;
			sk |= skip_o;
		end while (done_o !== 1'b1 && n_cyc < 9);
		if (done_o !== 1'b1) begin
			n_errors++;
			report_and_stop();
		end
		@(negedge mclk_i);
	endtask : run
	////////////////////////////////////////////////////////////////////////
	task automatic t_swap_xor;
		mem[8'h10] = 8'h3C;
		run(STX_OP_SWAP_REG, 8'h10, 8'h00);
		base = 2;
		chk(16'(n_cyc), 16'(base));
		chk(work_register_o, 16'h00C3);
		chk(mem[8'h10], 16'h003C);
		run(STX_OP_XOR_REG, 8'h10, 8'h00);
		chk({work_register_o, 7'h00, zero_flag_o}, 16'hFF00);
		run(STX_OP_XOR_IMM, 8'h10, 8'h5A);
		chk({work_register_o, 7'h00, zero_flag_o}, 16'hA500);
		run(STX_OP_XOR_MEM, 8'h10, 8'h00);
		chk({mem[8'h10], 7'h00, zero_flag_o}, 16'h9900);
		run(STX_OP_XOR_IMM, 8'h10, 8'hA5);
		chk({work_register_o, 7'h00, zero_flag_o}, 16'h0001);
	endtask : t_swap_xor
	task automatic t_skip;
		stx_op_type ops [6] = '{STX_OP_SKIP_NULL, STX_OP_SKIP_NULL,
			STX_OP_SKIP_MOVE, STX_OP_SKIP_MOVE, STX_OP_SKIP_BIT, STX_OP_SKIP_BIT};
		logic [7:0] v [6] = '{8'h00, 8'h5A, 8'h00, 8'hA5, 8'hF7, 8'h08};
		for (int i = 0; i < 6; i++) begin
			mem[8'h20] = v[i];
			run(ops[i], 8'h20, 8'h00);
			chk(sk, 16'(i % 2 == 0));
			chk(16'(n_cyc), 16'(base + (i % 2 == 0)));
			chk(mem[8'h20], v[i]);
			if (i / 2 == 1) chk(work_register_o, v[i]);
		end
	endtask : t_skip
	task automatic t_table;
		@(posedge mclk_i);
		table_pointer_low_i <= 8'h34;
		table_pointer_high_i <= 8'h12;
		run(STX_OP_TBL_PAGE, 8'h30, 8'h00);
		chk(prog_addr_o, 16'h1234);
		chk({table_high_latch_o, mem[8'h30]}, 16'hB76E);
		run(STX_OP_TBL_LAST, 8'h31, 8'h00);
		chk(prog_addr_o, 16'hFF34);
		chk({table_high_latch_o, mem[8'h31]}, 16'h5A6E);
	endtask : t_table
	////////////////////////////////////////////////////////////////////////
	initial begin
		{mclk_i, issue_valid_i, issue_i, n_errors, comparisons} = '0;
		{table_pointer_low_i, table_pointer_high_i} = '0;
		rst_i = 1'b1;
		foreach (mem[i]) mem[i] = 8'hFF;
		repeat (10) @(posedge mclk_i);
		rst_i <= 1'b0;
		t_swap_xor();
		t_skip();
		t_table();
		report_and_stop();
	end
endmodule : testbench
